// >>> logic/merr_consts.vh
// Register map, field positions and reset values of the memory error block
`ifndef MERR_CONSTS_VH
`define MERR_CONSTS_VH
// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define MERR_ADDR_W 16
`define MERR_OFS_FATAL_IND 16'h1084
`define MERR_OFS_FATAL_MASK 16'h1088
`define MERR_OFS_PB_ECC 16'h245C
`define MERR_OFS_HL_CTL 16'h5BA0
`define MERR_OFS_HL_STS 16'h5BA8
`define MERR_OFS_RETX_CTL 16'h5F54
`define MERR_OFS_RETX_STS 16'h5F58
// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define MERR_FATAL_LAN 0
`define MERR_FATAL_MNG 1
`define MERR_FATAL_HL 2
`define MERR_FATAL_DMA 3
`define MERR_FATAL_W 4
`define MERR_PB_ECC_EN_BIT 0
`define MERR_PB_COR_BIT 2
`define MERR_GPAR_BIT 0
`define MERR_QEN_LSB 6
`define MERR_QSTS_LSB 3
`define MERR_NQ 4
`define MERR_RETX_BIT 9
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MERR_RST_FATAL_IND 4'h0
`define MERR_RST_FATAL_MASK 4'hF
`define MERR_RST_ECC_EN 1'b1
`define MERR_RST_QEN 4'hF
`define MERR_RST_GPAR 1'b0
`define MERR_RST_RETX_EN 1'b1
`endif

// >>> logic/merr_sticky.v
// Sticky flag bank: hardware set wins over software clear
`timescale 1ns/10ps
`include "merr_consts.vh"
module merr_sticky #(
   parameter W = 4
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] set,
   input wire [W-1:0] clr,
   output reg [W-1:0] flag_q
);
   wire [W-1:0] flag_d;
   // An event in the clearing cycle is kept
   assign flag_d = set | (flag_q & ~clr);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= {W{1'b0}};
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule // merr_sticky

// >>> logic/merr_gpar.v
// Global parity enable, kept across all resets but power-good
`timescale 1ns/10ps
`include "merr_consts.vh"
module merr_gpar (
   input wire pclk,
   input wire lan_power_good_n,
   input wire wr,
   input wire wdata,
   output reg global_parity_enable_q
);
   always @(posedge pclk or negedge lan_power_good_n) begin
      if (!lan_power_good_n) begin
         global_parity_enable_q <= `MERR_RST_GPAR;
      end else if (wr) begin
         global_parity_enable_q <= wdata;
      end
   end
endmodule // merr_gpar

// >>> logic/merr_regs.v
// Memory error report registers with APB slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`include "merr_consts.vh"
module merr_regs (
   input wire pclk,
   input wire presetn,
   input wire lan_power_good_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire lan_mem_fatal_err,
   input wire mng_mem_fatal_err,
   input wire dma_mem_fatal_err,
   input wire buffer_corrected_err,
   input wire [3:0] queue_ram_parity_err,
   input wire retx_parity_err,
   output wire buffer_ecc_enable,
   output wire [3:0] queue_ram_check_active,
   output wire retx_check_active,
   output wire host_link_halt,
   output wire transmit_disable,
   output wire fatal_error_interrupt_cause
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   localparam NIN = 9;
   wire [NIN-1:0] raw_in;
   reg [NIN-1:0] sync1_q;
   reg [NIN-1:0] sync2_q;
   assign raw_in = {retx_parity_err, queue_ram_parity_err,
      buffer_corrected_err, dma_mem_fatal_err, mng_mem_fatal_err,
      lan_mem_fatal_err};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= {NIN{1'b0}};
         sync2_q <= {NIN{1'b0}};
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end
   wire lan_err_s;
   wire mng_err_s;
   wire dma_err_s;
   wire cor_err_s;
   wire [3:0] q_err_s;
   wire retx_err_s;
   assign lan_err_s = sync2_q[0];
   assign mng_err_s = sync2_q[1];
   assign dma_err_s = sync2_q[2];
   assign cor_err_s = sync2_q[3];
   assign q_err_s = sync2_q[7:4];
   assign retx_err_s = sync2_q[8];

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   // Zero-wait slave: every access completes in its first access cycle
   function hit;
      input [15:0] a;
      input [15:0] ofs;
      begin
         hit = (a[15:2] == ofs[15:2]);
      end
   endfunction

   // Queue enables sit on every other bit from bit 6 upward
   function [3:0] qen_from_word;
      input [31:0] w;
      begin
         qen_from_word = {w[`MERR_QEN_LSB+6], w[`MERR_QEN_LSB+4],
            w[`MERR_QEN_LSB+2], w[`MERR_QEN_LSB]};
      end
   endfunction

   function [31:0] qen_to_word;
      input [3:0] q;
      begin
         qen_to_word = 32'h0000_0000;
         qen_to_word[`MERR_QEN_LSB] = q[0];
         qen_to_word[`MERR_QEN_LSB+2] = q[1];
         qen_to_word[`MERR_QEN_LSB+4] = q[2];
         qen_to_word[`MERR_QEN_LSB+6] = q[3];
      end
   endfunction

   wire access;
   wire wr_en;
   wire rd_en;
   assign access = psel & penable;
   assign wr_en = access & pwrite;
   assign rd_en = access & ~pwrite;
   assign pready = 1'b1;

   // ---------------------------------------------------------------
   // Register select
   // ---------------------------------------------------------------
   wire hit_ind;
   wire hit_mask;
   wire hit_ecc;
   wire hit_ctl;
   wire hit_sts;
   wire hit_rctl;
   wire hit_rsts;
   assign hit_ind = hit(paddr, `MERR_OFS_FATAL_IND);
   assign hit_mask = hit(paddr, `MERR_OFS_FATAL_MASK);
   assign hit_ecc = hit(paddr, `MERR_OFS_PB_ECC);
   assign hit_ctl = hit(paddr, `MERR_OFS_HL_CTL);
   assign hit_sts = hit(paddr, `MERR_OFS_HL_STS);
   assign hit_rctl = hit(paddr, `MERR_OFS_RETX_CTL);
   assign hit_rsts = hit(paddr, `MERR_OFS_RETX_STS);
   wire mapped;
   assign mapped = hit_ind | hit_mask | hit_ecc | hit_ctl | hit_sts
      | hit_rctl | hit_rsts;
   // Unmapped addresses read zero and flag an error
   assign pslverr = access & ~mapped;

   wire wr_mask;
   wire wr_ecc;
   wire wr_ctl;
   wire wr_sts;
   wire wr_rctl;
   wire wr_rsts;
   wire rd_ind;
   assign wr_mask = wr_en & hit(paddr, `MERR_OFS_FATAL_MASK);
   assign wr_ecc = wr_en & hit(paddr, `MERR_OFS_PB_ECC);
   assign wr_ctl = wr_en & hit(paddr, `MERR_OFS_HL_CTL);
   assign wr_sts = wr_en & hit(paddr, `MERR_OFS_HL_STS);
   assign wr_rctl = wr_en & hit(paddr, `MERR_OFS_RETX_CTL);
   assign wr_rsts = wr_en & hit(paddr, `MERR_OFS_RETX_STS);
   assign rd_ind = rd_en & hit(paddr, `MERR_OFS_FATAL_IND);

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   reg [3:0] fatal_mask_q;
   reg ecc_en_q;
   reg [3:0] queue_ram_check_enable_q;
   reg retx_en_q;
   wire global_parity_enable;
   wire [3:0] qen_wdata;
   wire [3:0] mask_wdata;
   wire ecc_en_wdata;
   wire retx_en_wdata;
   wire gpar_wdata;
   assign qen_wdata = qen_from_word(pwdata);
   assign mask_wdata = pwdata[`MERR_FATAL_W-1:0];
   assign ecc_en_wdata = pwdata[`MERR_PB_ECC_EN_BIT];
   assign retx_en_wdata = pwdata[`MERR_RETX_BIT];
   assign gpar_wdata = pwdata[`MERR_GPAR_BIT];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fatal_mask_q <= `MERR_RST_FATAL_MASK;
         ecc_en_q <= `MERR_RST_ECC_EN;
         queue_ram_check_enable_q <= `MERR_RST_QEN;
         retx_en_q <= `MERR_RST_RETX_EN;
      end else begin
         if (wr_mask) begin
            fatal_mask_q <= mask_wdata;
         end
         if (wr_ecc) begin
            ecc_en_q <= ecc_en_wdata;
         end
         if (wr_ctl) begin
            queue_ram_check_enable_q <= qen_wdata;
         end
         if (wr_rctl) begin
            retx_en_q <= retx_en_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Global parity enable
   // ---------------------------------------------------------------
   merr_gpar u_gpar (
      .pclk(pclk),
      .lan_power_good_n(lan_power_good_n),
      .wr(wr_ctl),
      .wdata(gpar_wdata),
      .global_parity_enable_q(global_parity_enable)
   );

   // Parity checks are qualified by the global enable
   assign queue_ram_check_active = queue_ram_check_enable_q
      & {4{global_parity_enable}};
   assign retx_check_active = retx_en_q & global_parity_enable;
   assign buffer_ecc_enable = ecc_en_q;

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   wire [3:0] q_sts;
   wire [3:0] q_set;
   wire [3:0] q_w1c;
   wire cor_set;
   wire cor_w1c;
   wire retx_set;
   wire retx_w1c;
   assign q_set = q_err_s & queue_ram_check_active;
   assign q_w1c = wr_sts ? pwdata[`MERR_QSTS_LSB+3:`MERR_QSTS_LSB] : 4'h0;
   // Corrected errors are only logged while correction is switched on
   assign cor_set = cor_err_s & ecc_en_q;
   assign cor_w1c = wr_ecc & pwdata[`MERR_PB_COR_BIT];
   assign retx_set = retx_err_s & retx_check_active;
   assign retx_w1c = wr_rsts & pwdata[`MERR_RETX_BIT];

   merr_sticky #(.W(4)) u_qsts (
      .pclk(pclk),
      .presetn(presetn),
      .set(q_set),
      .clr(q_w1c),
      .flag_q(q_sts)
   );

   wire [0:0] cor_sts;
   merr_sticky #(.W(1)) u_cor (
      .pclk(pclk),
      .presetn(presetn),
      .set(cor_set),
      .clr(cor_w1c),
      .flag_q(cor_sts)
   );

   wire [0:0] retx_sts;
   merr_sticky #(.W(1)) u_retx (
      .pclk(pclk),
      .presetn(presetn),
      .set(retx_set),
      .clr(retx_w1c),
      .flag_q(retx_sts)
   );

   // ---------------------------------------------------------------
   // Fatal indication
   // ---------------------------------------------------------------
   wire lan_fatal_set;
   wire hl_fatal_set;
   wire [3:0] fatal_set;
   wire [3:0] fatal_rc;
   wire [3:0] fatal_ind;
   wire [3:0] fatal_pending;
   // A retransmit parity error is a LAN port memory fault
   assign lan_fatal_set = lan_err_s | retx_set;
   // Host-link fatal follows the queue status on the same edge
   assign hl_fatal_set = |q_set;
   assign fatal_set = {dma_err_s, hl_fatal_set, mng_err_s, lan_fatal_set};
   // Only bits the reader was shown are cleared, so an event landing on
   // the setup edge survives to the next read; one on the access edge
   // wins over the clear
   assign fatal_rc = rd_ind ? prdata[`MERR_FATAL_W-1:0] : 4'h0;
   merr_sticky #(.W(`MERR_FATAL_W)) u_fatal (
      .pclk(pclk),
      .presetn(presetn),
      .set(fatal_set),
      .clr(fatal_rc),
      .flag_q(fatal_ind)
   );

   // ---------------------------------------------------------------
   // Traffic control and interrupt cause
   // ---------------------------------------------------------------
   assign fatal_pending = fatal_ind & fatal_mask_q;
   assign fatal_error_interrupt_cause = |fatal_pending;
   // Halt stays up until software has cleared every status bit
   assign host_link_halt = |q_sts;
   assign transmit_disable = retx_sts[0];

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   wire [31:0] word_ind;
   wire [31:0] word_mask;
   wire [31:0] word_ecc;
   wire [31:0] word_ctl;
   wire [31:0] word_sts;
   wire [31:0] word_rctl;
   wire [31:0] word_rsts;
   assign word_ind = {28'h0, fatal_ind};
   assign word_mask = {28'h0, fatal_mask_q};
   assign word_ecc = {29'h0, cor_sts[0], 1'b0, ecc_en_q};
   assign word_ctl = qen_to_word(queue_ram_check_enable_q)
      | {31'h0, global_parity_enable};
   assign word_sts = {25'h0, q_sts, 3'h0};
   assign word_rctl = {22'h0, retx_en_q, 9'h000};
   assign word_rsts = {22'h0, retx_sts[0], 9'h000};
   reg [31:0] rd_mux;
   // Selects are mutually exclusive; unmapped addresses read zero
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit_ind) begin
         rd_mux = word_ind;
      end
      if (hit_mask) begin
         rd_mux = word_mask;
      end
      if (hit_ecc) begin
         rd_mux = word_ecc;
      end
      if (hit_ctl) begin
         rd_mux = word_ctl;
      end
      if (hit_sts) begin
         rd_mux = word_sts;
      end
      if (hit_rctl) begin
         rd_mux = word_rctl;
      end
      if (hit_rsts) begin
         rd_mux = word_rsts;
      end
   end

   wire rd_setup;
   assign rd_setup = psel & ~penable & ~pwrite;
   // Read data is registered at the setup cycle so it is stable in access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end
endmodule // merr_regs

// >>> bench/merr_regs_asserts.sv
// Assertion checker for the memory error report registers
`timescale 1ns/10ps
`include "merr_consts.vh"
module merr_regs_chk (
   input wire pclk,
   input wire presetn,
   input wire lan_power_good_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire lan_mem_fatal_err,
   input wire mng_mem_fatal_err,
   input wire dma_mem_fatal_err,
   input wire buffer_corrected_err,
   input wire [3:0] queue_ram_parity_err,
   input wire retx_parity_err,
   input wire buffer_ecc_enable,
   input wire [3:0] queue_ram_check_active,
   input wire retx_check_active,
   input wire host_link_halt,
   input wire transmit_disable,
   input wire fatal_error_interrupt_cause
);
   wire [15:0] wa = {paddr[15:2], 2'b00};
   wire wr = psel & penable & pwrite;
   wire q_clr = wr && wa == `MERR_OFS_HL_STS && |pwdata[6:3];
   wire t_clr = wr && wa == `MERR_OFS_RETX_STS && pwdata[9];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // Error capture
   // ---------------------------------------------------------------
   // Two sync stages sit in front of the status flags
   sequence s_qerr;
      |(queue_ram_parity_err & queue_ram_check_active);
   endsequence
   sequence s_terr;
      retx_parity_err && retx_check_active;
   endsequence
   property p_qset;
      s_qerr |-> ##[1:4] host_link_halt;
   endproperty
   a_qset: assert property (p_qset)
      else $error("queue parity error did not halt");
   property p_qhold;
      host_link_halt && !q_clr |=> host_link_halt;
   endproperty
   a_qhold: assert property (p_qhold)
      else $error("halt dropped without clear");
   property p_tset;
      s_terr |-> ##[1:4] transmit_disable;
   endproperty
   a_tset: assert property (p_tset)
      else $error("retransmit error did not stop transmit");
   property p_thold;
      transmit_disable && !t_clr |=> transmit_disable;
   endproperty
   a_thold: assert property (p_thold)
      else $error("transmit disable dropped without clear");
   // ---------------------------------------------------------------
   // Enables
   // ---------------------------------------------------------------
   property p_gpar_off;
      !lan_power_good_n |-> queue_ram_check_active == 4'h0
         && !retx_check_active;
   endproperty
   a_gpar_off: assert property (p_gpar_off)
      else $error("checks active without global enable");
   property p_gpar_keep;
      disable iff (!lan_power_good_n)
      !presetn && $past(retx_check_active) |->
         retx_check_active && queue_ram_check_active == 4'hF;
   endproperty
   a_gpar_keep: assert property (p_gpar_keep)
      else $error("global enable lost on ordinary reset");
   property p_ecc;
      wr && wa == `MERR_OFS_PB_ECC |=> buffer_ecc_enable == $past(pwdata[0]);
   endproperty
   a_ecc: assert property (p_ecc)
      else $error("ecc enable not written");
   property p_mask;
      wr && wa == `MERR_OFS_FATAL_MASK && pwdata[3:0] == 4'h0
         |=> !fatal_error_interrupt_cause;
   endproperty
   a_mask: assert property (p_mask)
      else $error("fatal cause with all sources masked");
endmodule // merr_regs_chk
bind merr_regs merr_regs_chk u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .lan_power_good_n(lan_power_good_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .lan_mem_fatal_err(lan_mem_fatal_err),
   .mng_mem_fatal_err(mng_mem_fatal_err),
   .dma_mem_fatal_err(dma_mem_fatal_err),
   .buffer_corrected_err(buffer_corrected_err),
   .queue_ram_parity_err(queue_ram_parity_err),
   .retx_parity_err(retx_parity_err),
   .buffer_ecc_enable(buffer_ecc_enable),
   .queue_ram_check_active(queue_ram_check_active),
   .retx_check_active(retx_check_active),
   .host_link_halt(host_link_halt),
   .transmit_disable(transmit_disable),
   .fatal_error_interrupt_cause(fatal_error_interrupt_cause)
);

// >>> bench/merr_tb.sv
// Self-checking bench for the memory error report registers
`timescale 1ns/10ps
`include "merr_consts.vh"
module testbench;
   reg pclk = 0;
   reg presetn = 0;
   reg lan_power_good_n = 0;
   reg psel = 0;
   reg penable = 0;
   reg pwrite = 0;
   reg [15:0] paddr = 16'h0;
   reg [31:0] pwdata = 32'h0;
   reg [8:0] ev = 9'h0;
   wire [31:0] prdata;
   wire pready, pslverr, buffer_ecc_enable, retx_check_active;
   wire host_link_halt, transmit_disable, fatal_error_interrupt_cause;
   wire [3:0] queue_ram_check_active;
   reg [31:0] rd;
   reg slv;
   integer error_cnt = 0;
   integer checks_done = 0;
   integer i;
   always #12.5 pclk = ~pclk;
   merr_regs DUT (.lan_mem_fatal_err(ev[0]), .mng_mem_fatal_err(ev[1]),
      .dma_mem_fatal_err(ev[2]), .buffer_corrected_err(ev[3]),
      .queue_ram_parity_err(ev[7:4]), .retx_parity_err(ev[8]),
      .pclk(pclk), .presetn(presetn), .lan_power_good_n(lan_power_good_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .buffer_ecc_enable(buffer_ecc_enable),
      .queue_ram_check_active(queue_ram_check_active),
      .retx_check_active(retx_check_active),
      .host_link_halt(host_link_halt),
      .transmit_disable(transmit_disable),
      .fatal_error_interrupt_cause(fatal_error_interrupt_cause));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", checks_done, error_cnt);
         if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input string n, input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s exp %h got %h", n, exp, got);
         end
      end
   endtask
   // Ends one idle edge after the access so the next setup is clean
   task apb(input [15:0] a, input w, input [31:0] d);
      integer n;
      begin
         psel <= 1'b1;
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 16);
         if (pready !== 1'b1) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
         end
         rd = prdata;
         slv = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rdchk(input string n, input [15:0] a, input [31:0] m, e);
      begin
         apb(a, 1'b0, 32'h0);
         chk(n, rd & m, e);
      end
   endtask
   task pulse(input [8:0] v);
      begin
         ev <= v;
         @(posedge pclk);
         ev <= 9'h0;
         repeat (4) @(posedge pclk);
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset;
      begin
         rdchk("ind", `MERR_OFS_FATAL_IND, 32'hFFFFFFFF, 32'h0);
         rdchk("mask", `MERR_OFS_FATAL_MASK, 32'hFFFFFFFF, 32'hF);
         rdchk("ecc", `MERR_OFS_PB_ECC, 32'hFFFFFFFF, 32'h1);
         rdchk("ctl", `MERR_OFS_HL_CTL, 32'h1541, 32'h1540);
         rdchk("sts", `MERR_OFS_HL_STS, 32'hFFFFFFFF, 32'h0);
         apb(16'h1000, 1'b0, 32'h0);
         chk("slverr", {31'h0, slv}, 32'h1);
         chk("unmapped", rd, 32'h0);
         chk("pready", {31'h0, pready}, 32'h1);
      end
   endtask
   task t_fatal;
      begin
         pulse(9'h007);
         chk("cause", {31'h0, fatal_error_interrupt_cause}, 32'h1);
         rdchk("ind", `MERR_OFS_FATAL_IND, 32'hF, 32'hB);
         rdchk("ind", `MERR_OFS_FATAL_IND, 32'hF, 32'h0);
         apb(`MERR_OFS_FATAL_MASK, 1'b1, 32'h0);
         pulse(9'h001);
         chk("masked", {31'h0, fatal_error_interrupt_cause}, 32'h0);
         rdchk("ind", `MERR_OFS_FATAL_IND, 32'hF, 32'h1);
         apb(`MERR_OFS_FATAL_MASK, 1'b1, 32'hF);
      end
   endtask
   task t_ecc;
      begin
         pulse(9'h008);
         rdchk("ecc", `MERR_OFS_PB_ECC, 32'h5, 32'h5);
         apb(`MERR_OFS_PB_ECC, 1'b1, 32'h5);
         rdchk("ecc", `MERR_OFS_PB_ECC, 32'h5, 32'h1);
         apb(`MERR_OFS_PB_ECC, 1'b1, 32'h0);
         chk("ecc_en", {31'h0, buffer_ecc_enable}, 32'h0);
         apb(`MERR_OFS_PB_ECC, 1'b1, 32'h1);
      end
   endtask
   task t_queue;
      begin
         pulse(9'h0F0);
         rdchk("off", `MERR_OFS_HL_STS, 32'h78, 32'h0);
         apb(`MERR_OFS_HL_CTL, 1'b1, 32'h1541);
         chk("act", {28'h0, queue_ram_check_active}, 32'hF);
         for (i = 0; i < 4; i = i + 1) begin
            pulse(9'h010 << i);
            chk("cause", {31'h0, fatal_error_interrupt_cause}, 32'h1);
            rdchk("sts", `MERR_OFS_HL_STS, 32'h78, 32'h8 << i);
            rdchk("hl", `MERR_OFS_FATAL_IND, 32'h4, 32'h4);
            apb(`MERR_OFS_HL_STS, 1'b1, 32'h0);
            chk("halt", {31'h0, host_link_halt}, 32'h1);
            apb(`MERR_OFS_HL_STS, 1'b1, 32'h8 << i);
            chk("halt", {31'h0, host_link_halt}, 32'h0);
         end
         apb(`MERR_OFS_HL_CTL, 1'b1, 32'h1501);
         pulse(9'h010);
         rdchk("dis", `MERR_OFS_HL_STS, 32'h78, 32'h0);
      end
   endtask
   task t_retx;
      begin
         pulse(9'h100);
         chk("txdis", {31'h0, transmit_disable}, 32'h1);
         apb(`MERR_OFS_RETX_STS, 1'b1, 32'h200);
         chk("txdis", {31'h0, transmit_disable}, 32'h0);
      end
   endtask
   task t_resets;
      begin
         pulse(9'h020);
         chk("halt", {31'h0, host_link_halt}, 32'h1);
         presetn <= 1'b0;
         repeat (5) @(posedge pclk);
         presetn <= 1'b1;
         @(posedge pclk);
         chk("recover", {31'h0, host_link_halt}, 32'h0);
         chk("keep", {28'h0, queue_ram_check_active}, 32'hF);
         lan_power_good_n <= 1'b0;
         repeat (2) @(posedge pclk);
         chk("pgood", {28'h0, queue_ram_check_active}, 32'h0);
         lan_power_good_n <= 1'b1;
      end
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      lan_power_good_n <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_fatal;
      t_ecc;
      t_queue;
      t_retx;
      t_resets;
      report_and_stop;
   end
endmodule // testbench
